/* rtl/three_pin_io_port_map.svh */
// Purpose: Addresses, field codes and reset values of the three-pin port.
// Assumes: Byte addresses on a 16-bit register port.
// Notes:   Definitions only.
// Notes on behaviour
// - Each pin's direction bit alone picks input or output for that pin.
// - Output drive codes: 00 hi-z, 01 P open drain, 10 N open drain, 11 CMOS.
// - Input codes: 00 hi-z, 01 pull-down, 10 pull-up, 11 hi-z.
// - Reset gives hi-z output; direction, drive and function registers cleared.
// - Output pins drive the data register bit, shaped by the driver style.
// - Reading data returns the live pin level for input pins.
// - Pin 2 functions: GPIO, prohibited, external clock input, comparator 0.
// - Pin 1 functions: GPIO, prohibited, low-speed clock, timer F.
// - Pin 0 functions: GPIO, PWM C, high-speed clock, timer 9.
// - Prohibited code ignores data; hi-z for hi-z/P drive, low for N and CMOS drive.
// - Drive and function low bytes also take 16-bit word access.
// - Each pin has its own interrupt with its own enable.
// - Interrupt edge is rising, falling or both, sampled or not.
// - Sampled mode samples on tick falls; two equal samples qualify.
// - Sampled request follows the second qualifying tick fall.
// - Direction 0 is output and reset state; 1 is input.
// - Reading data returns the written value for output pins.
`ifndef THREE_PIN_IO_PORT_MAP_SVH
`define THREE_PIN_IO_PORT_MAP_SVH

`define ADDR_DATA      16'hf250
`define ADDR_DIR       16'hf251
`define ADDR_DRV_LO    16'hf252
`define ADDR_DRV_HI    16'hf253
`define ADDR_FN_LO     16'hf254
`define ADDR_FN_HI     16'hf255
`define ADDR_EDGE_RISE 16'hf2e0
`define ADDR_EDGE_FALL 16'hf2e1
`define ADDR_EDGE_SAMP 16'hf2e2
`define ADDR_IRQ_STAT  16'hf2e3
`define ADDR_IRQ_MASK  16'hf2e4

`define DRV_HIZ  2'h0
`define DRV_PCH  2'h1
`define DRV_NCH  2'h2
`define DRV_CMOS 2'h3

`define FN_GPIO 2'h0
`define FN_ALT1 2'h1
`define FN_ALT2 2'h2
`define FN_ALT3 2'h3

`define PIN_RESET 3'h0

`endif

/* rtl/three_pin_io_port_pkg.sv */
// Purpose: Types of the three-pin port.
// Assumes: Three pins, byte registers.
// Notes:   The whole block state is one packed struct.
`default_nettype none

package three_pin_io_port_pkg;

    typedef logic [2:0] pin_vec_t;

    typedef struct packed {
        pin_vec_t    data;
        pin_vec_t    dir;
        pin_vec_t    drv_lo;
        pin_vec_t    drv_hi;
        pin_vec_t    fn_lo;
        pin_vec_t    fn_hi;
        pin_vec_t    rise_en;
        pin_vec_t    fall_en;
        pin_vec_t    samp_en;
        pin_vec_t    status;
        pin_vec_t    mask;
        pin_vec_t    pin_prev;
        pin_vec_t    samp_prev;
        pin_vec_t    qual;
        logic        tick_prev;
        logic [15:0] rdata;
        pin_vec_t    pin_o;
        pin_vec_t    pin_oe;
        pin_vec_t    pull_up;
        pin_vec_t    pull_down;
        logic        ext_clk;
    } state_t;

endpackage : three_pin_io_port_pkg

`default_nettype wire

/* rtl/three_pin_io_port.sv */
// Purpose: Three-pin I/O port with drive styles, pin functions, pin interrupts.
// Assumes: Pins and tick are synchronous to clock_in.
// Notes:   Pin drive is registered, so it follows a register write by one cycle.
//
// The address-and-strobe port was decided locally.
`default_nettype none
`include "three_pin_io_port_map.svh"

module three_pin_io_port #(
    parameter int ADDR_WIDTH = 16
) (
    input  wire logic                                 clock_in,
    input  wire logic                                 nrst_in,
    input  wire logic [ADDR_WIDTH-1:0]                addr_in,
    input  wire logic [15:0]                          wdata_in,
    input  wire logic                                 wr_in,
    input  wire logic                                 rd_in,
    input  wire logic                                 word_in,
    output logic      [15:0]                          rdata_out,
    input  wire three_pin_io_port_pkg::pin_vec_t      port_pin_in,
    output three_pin_io_port_pkg::pin_vec_t           port_pin_out,
    output three_pin_io_port_pkg::pin_vec_t           port_pin_oe_out,
    output three_pin_io_port_pkg::pin_vec_t           pull_up_out,
    output three_pin_io_port_pkg::pin_vec_t           pull_down_out,
    input  wire logic                                 pwm_channel_c_out_in,
    input  wire logic                                 high_speed_clock_out_in,
    input  wire logic                                 timer_nine_out_in,
    input  wire logic                                 low_speed_clock_out_in,
    input  wire logic                                 timer_f_out_in,
    input  wire logic                                 comparator_zero_result_in,
    output logic                                      external_clock_in_out,
    input  wire logic                                 sixteen_khz_tick_in,
    output three_pin_io_port_pkg::pin_vec_t           pin_interrupt_out,
    output logic                                      irq_out
);
    import three_pin_io_port_pkg::*;

    initial begin
        if (ADDR_WIDTH < 16) begin
            $error("ADDR_WIDTH must be at least 16");
        end
    end

    state_t            st;
    state_t            next_st;
    logic   [15:0]     addr;
    pin_vec_t          lvl;
    pin_vec_t          proh;
    pin_vec_t          ev;
    pin_vec_t          clr;
    pin_vec_t          next_qual;
    logic              tick_fall;
    logic   [1:0]      drv;
    logic              byte_wr;
    logic              word_wr;

    assign addr = addr_in[15:0];

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_st   = st;
        lvl       = st.data;
        proh      = '0;
        ev        = '0;
        clr       = '0;
        next_qual = st.qual;
        drv       = `DRV_HIZ;
        byte_wr   = wr_in && !word_in;
        word_wr   = wr_in && word_in;
        tick_fall = st.tick_prev && !sixteen_khz_tick_in;

        // Read data stands one cycle after the strobe, zero otherwise
        next_st.rdata = '0;
        if (rd_in && !word_in) begin
            case (addr)
                // Input pins show the live level, outputs the stored bit
                `ADDR_DATA:      next_st.rdata[2:0] = (port_pin_in & st.dir) |
                                                      (st.data & ~st.dir);
                `ADDR_DIR:       next_st.rdata[2:0] = st.dir;
                `ADDR_DRV_LO:    next_st.rdata[2:0] = st.drv_lo;
                `ADDR_DRV_HI:    next_st.rdata[2:0] = st.drv_hi;
                `ADDR_FN_LO:     next_st.rdata[2:0] = st.fn_lo;
                `ADDR_FN_HI:     next_st.rdata[2:0] = st.fn_hi;
                `ADDR_EDGE_RISE: next_st.rdata[2:0] = st.rise_en;
                `ADDR_EDGE_FALL: next_st.rdata[2:0] = st.fall_en;
                `ADDR_EDGE_SAMP: next_st.rdata[2:0] = st.samp_en;
                `ADDR_IRQ_STAT:  next_st.rdata[2:0] = st.status;
                `ADDR_IRQ_MASK:  next_st.rdata[2:0] = st.mask;
                default:         next_st.rdata = '0;
            endcase
        end else if (rd_in) begin
            // Word reads exist only on the two even control addresses
            case (addr)
                `ADDR_DRV_LO: next_st.rdata = {5'h00, st.drv_hi,
                                               5'h00, st.drv_lo};
                `ADDR_FN_LO:  next_st.rdata = {5'h00, st.fn_hi,
                                               5'h00, st.fn_lo};
                default:      next_st.rdata = '0;
            endcase
        end

        // Byte writes; upper bits are simply not stored
        if (byte_wr) begin
            case (addr)
                `ADDR_DATA:      next_st.data    = wdata_in[2:0];
                `ADDR_DIR:       next_st.dir     = wdata_in[2:0];
                `ADDR_DRV_LO:    next_st.drv_lo  = wdata_in[2:0];
                `ADDR_DRV_HI:    next_st.drv_hi  = wdata_in[2:0];
                `ADDR_FN_LO:     next_st.fn_lo   = wdata_in[2:0];
                `ADDR_FN_HI:     next_st.fn_hi   = wdata_in[2:0];
                `ADDR_EDGE_RISE: next_st.rise_en = wdata_in[2:0];
                `ADDR_EDGE_FALL: next_st.fall_en = wdata_in[2:0];
                `ADDR_EDGE_SAMP: next_st.samp_en = wdata_in[2:0];
                `ADDR_IRQ_STAT:  clr             = wdata_in[2:0];
                `ADDR_IRQ_MASK:  next_st.mask    = wdata_in[2:0];
                default:         next_st.mask    = st.mask;
            endcase
        end

        // Word writes fill the even byte and its companion together
        if (word_wr) begin
            case (addr)
                `ADDR_DRV_LO: begin
                    next_st.drv_lo = wdata_in[2:0];
                    next_st.drv_hi = wdata_in[10:8];
                end
                `ADDR_FN_LO: begin
                    next_st.fn_lo = wdata_in[2:0];
                    next_st.fn_hi = wdata_in[10:8];
                end
                default: next_st.fn_lo = st.fn_lo;
            endcase
        end

        // Sampled level qualifies only after two equal tick samples
        next_st.tick_prev = sixteen_khz_tick_in;
        next_st.pin_prev  = port_pin_in;
        if (tick_fall) begin
            next_st.samp_prev = port_pin_in;
            next_qual = (port_pin_in & st.samp_prev) |
                        (st.qual & (port_pin_in ^ st.samp_prev));
        end
        next_st.qual = next_qual;

        // Edge events, sampled or direct per pin
        for (int i = 0; i < 3; i++) begin
            if (st.samp_en[i]) begin
                ev[i] = (st.rise_en[i] && next_qual[i] && !st.qual[i]) ||
                        (st.fall_en[i] && !next_qual[i] && st.qual[i]);
            end else begin
                ev[i] = (st.rise_en[i] && port_pin_in[i] && !st.pin_prev[i]) ||
                        (st.fall_en[i] && !port_pin_in[i] && st.pin_prev[i]);
            end
        end
        // A new event wins over a clear in the same cycle
        next_st.status = (st.status & ~clr) | ev;

        // Function level per pin; an unused source leaves the data bit
        case ({st.fn_hi[0], st.fn_lo[0]})
            `FN_ALT1: lvl[0] = pwm_channel_c_out_in;
            `FN_ALT2: lvl[0] = high_speed_clock_out_in;
            `FN_ALT3: lvl[0] = timer_nine_out_in;
            default:  lvl[0] = st.data[0];
        endcase
        case ({st.fn_hi[1], st.fn_lo[1]})
            `FN_ALT1: proh[1] = 1'b1;
            `FN_ALT2: lvl[1]  = low_speed_clock_out_in;
            `FN_ALT3: lvl[1]  = timer_f_out_in;
            default:  lvl[1]  = st.data[1];
        endcase
        case ({st.fn_hi[2], st.fn_lo[2]})
            `FN_ALT1: proh[2] = 1'b1;
            `FN_ALT3: lvl[2]  = comparator_zero_result_in;
            default:  lvl[2]  = st.data[2];
        endcase
        next_st.ext_clk = ({st.fn_hi[2], st.fn_lo[2]} == `FN_ALT2) &&
                          port_pin_in[2];

        // Driver and termination per pin
        for (int i = 0; i < 3; i++) begin
            drv = {st.drv_hi[i], st.drv_lo[i]};
            next_st.pin_o[i]     = 1'b0;
            next_st.pin_oe[i]    = 1'b0;
            next_st.pull_up[i]   = 1'b0;
            next_st.pull_down[i] = 1'b0;
            if (st.dir[i]) begin
                next_st.pull_down[i] = (drv == `DRV_PCH);
                next_st.pull_up[i]   = (drv == `DRV_NCH);
            end else if (proh[i]) begin
                // Pulled low for N and CMOS drive, floating otherwise
                next_st.pin_oe[i] = (drv == `DRV_NCH) || (drv == `DRV_CMOS);
            end else begin
                case (drv)
                    `DRV_PCH: begin
                        next_st.pin_o[i]  = 1'b1;
                        next_st.pin_oe[i] = lvl[i];
                    end
                    `DRV_NCH:  next_st.pin_oe[i] = !lvl[i];
                    `DRV_CMOS: begin
                        next_st.pin_o[i]  = lvl[i];
                        next_st.pin_oe[i] = 1'b1;
                    end
                    default:   next_st.pin_oe[i] = 1'b0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; reset clears everything, pins float as outputs
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign rdata_out             = st.rdata;
    assign port_pin_out          = st.pin_o;
    assign port_pin_oe_out       = st.pin_oe;
    assign pull_up_out           = st.pull_up;
    assign pull_down_out         = st.pull_down;
    assign external_clock_in_out = st.ext_clk;
    // Level interrupt; mask bit 1 lets the pin through
    assign pin_interrupt_out     = st.status & st.mask;
    assign irq_out               = |(st.status & st.mask);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    AST_INPUT_FLOATS: assert property (
        st.dir[0] |=> !port_pin_oe_out[0])
        else $error("input pin driven");
    AST_CMOS_LEVEL: assert property (
        (!st.dir[0] && st.drv_hi[0] && st.drv_lo[0] && !st.fn_hi[0] && !st.fn_lo[0])
        |=> port_pin_oe_out[0] && (port_pin_out[0] == $past(st.data[0])))
        else $error("CMOS output wrong");
    AST_PULL_UP: assert property (
        (st.dir[1] && st.drv_hi[1] && !st.drv_lo[1])
        |=> pull_up_out[1] && !pull_down_out[1])
        else $error("pull-up missing");
    AST_RESET_HIZ: assert property (
        $rose(nrst_in) |-> st.dir == 3'h0 && st.drv_lo == `PIN_RESET && st.fn_hi == `PIN_RESET)
        else $error("reset state wrong");
    AST_READ_LIVE: assert property (
        (rd_in && !word_in && addr == `ADDR_DATA && st.dir[2])
        |=> rdata_out[2] == $past(port_pin_in[2]))
        else $error("input read not live");
    AST_READ_BACK: assert property (
        (rd_in && !word_in && addr == `ADDR_DATA && !st.dir[0])
        |=> rdata_out[0] == $past(st.data[0]))
        else $error("output read-back wrong");
    AST_TIMER9: assert property (
        (!st.dir[0] && st.drv_hi[0] && st.drv_lo[0] && st.fn_hi[0] && st.fn_lo[0])
        |=> port_pin_out[0] == $past(timer_nine_out_in))
        else $error("timer 9 not routed");
    AST_TIMERF: assert property (
        (!st.dir[1] && st.drv_hi[1] && st.drv_lo[1] && st.fn_hi[1] && st.fn_lo[1])
        |=> port_pin_out[1] == $past(timer_f_out_in))
        else $error("timer F not routed");
    AST_COMPARATOR: assert property (
        (!st.dir[2] && st.drv_hi[2] && st.drv_lo[2] && st.fn_hi[2] && st.fn_lo[2])
        |=> port_pin_out[2] == $past(comparator_zero_result_in))
        else $error("comparator not routed");
    AST_PROHIBITED_LOW: assert property (
        (!st.dir[1] && !st.fn_hi[1] && st.fn_lo[1] && st.drv_hi[1] && !st.drv_lo[1])
        |=> port_pin_oe_out[1] && !port_pin_out[1])
        else $error("prohibited N pin not low");
    AST_WORD_WRITE: assert property (
        (wr_in && word_in && addr == `ADDR_FN_LO)
        |=> st.fn_hi == $past(wdata_in[10:8]) && st.fn_lo == $past(wdata_in[2:0]))
        else $error("word write lost");
    AST_RESERVED_ZERO: assert property (
        (rd_in && addr == `ADDR_DRV_HI) |=> rdata_out[15:3] == 13'h0000)
        else $error("reserved bits set");
    AST_DIRECT_EDGE: assert property (
        (!st.samp_en[0] && st.rise_en[0] && port_pin_in[0] && !st.pin_prev[0])
        |=> st.status[0])
        else $error("edge request missing");
    AST_SAMPLED_EDGE: assert property (
        (st.samp_en[1] && !st.rise_en[1] && !st.fall_en[1]) |=> !$rose(st.status[1]))
        else $error("disabled sampled pin fired");
    AST_MASK_GATE: assert property (
        (st.mask == 3'h0) |-> !irq_out ##1 (st.mask != 3'h0 || !irq_out))
        else $error("masked interrupt seen");

    COV_SAMPLED_IRQ: cover property (st.samp_en[0] && $rose(st.status[0]));
    COV_WORD_READ: cover property (rd_in && word_in && addr == `ADDR_DRV_LO);
    COV_SET_AND_CLEAR: cover property (wr_in && addr == `ADDR_IRQ_STAT && |ev);

endmodule : three_pin_io_port

`default_nettype wire

/* verification/three_pin_io_port_ext.sv */
// Purpose: External circuitry on the three port pins.
// Assumes: The bench commands an external driver per pin.
// Notes:   An undriven pin with no pull toggles every cycle, so a stale level never passes.
`default_nettype none

module three_pin_io_port_ext (
    input  wire logic       clock_in,
    input  wire logic [2:0] pin_out_in,
    input  wire logic [2:0] pin_oe_in,
    input  wire logic [2:0] pull_up_in,
    input  wire logic [2:0] pull_down_in,
    input  wire logic [2:0] drive_en_in,
    input  wire logic [2:0] level_in,
    output logic      [2:0] pin_level_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] flt = 3'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Floating pattern; the simulator must not settle an open wire for us
    always_ff @(posedge clock_in) begin
        flt <= ~flt;
    end

    // Device drive wins, then the outside driver, then the terminations
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (pin_oe_in[i])
                pin_level_out[i] = pin_out_in[i];
            else if (drive_en_in[i])
                pin_level_out[i] = level_in[i];
            else if (pull_up_in[i] | pull_down_in[i])
                pin_level_out[i] = pull_up_in[i];
            else
                pin_level_out[i] = flt[i];
        end
    end
endmodule : three_pin_io_port_ext

`default_nettype wire

/* verification/three_pin_io_port_tb.sv */
// Purpose: Self-checking bench of the three-pin port.
// Assumes: Inputs change by non-blocking assignment at the rising clock edge.
// Notes:   The 16 kHz tick is real rate, so sampled cases cost a few thousand cycles.
`default_nettype none
`include "three_pin_io_port_map.svh"

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); end end

module three_pin_io_port_tb;
    import three_pin_io_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        word = 1'b0;
    logic        tick = 1'b0;
    logic [15:0] addr = 16'h0;
    logic [15:0] wdata = 16'h0;
    logic [5:0]  src = 6'h0;
    logic [2:0]  ext_en = 3'h0;
    logic [2:0]  ext_lv = 3'h0;
    logic [15:0] rdata;
    pin_vec_t    pin_lv, pin_o, pin_oe, pu, pd, irqv;
    logic        ext_clk, irq;
    int          tcnt = 0;
    int          mismatches = 0;
    int          n_checks = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // 40 MHz clock and a 16 kHz tick derived from it
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        if (tcnt == 1249) begin
            tcnt <= 0;
            tick <= ~tick;
        end else
            tcnt <= tcnt + 1;
    end

    three_pin_io_port dut (
        .clock_in(clk), .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .word_in(word), .rdata_out(rdata),
        .port_pin_in(pin_lv), .port_pin_out(pin_o), .port_pin_oe_out(pin_oe),
        .pull_up_out(pu), .pull_down_out(pd),
        .pwm_channel_c_out_in(src[0]), .high_speed_clock_out_in(src[1]),
        .timer_nine_out_in(src[2]), .low_speed_clock_out_in(src[3]),
        .timer_f_out_in(src[4]), .comparator_zero_result_in(src[5]),
        .external_clock_in_out(ext_clk), .sixteen_khz_tick_in(tick),
        .pin_interrupt_out(irqv), .irq_out(irq));

    three_pin_io_port_ext ext (
        .clock_in(clk), .pin_out_in(pin_o), .pin_oe_in(pin_oe), .pull_up_in(pu),
        .pull_down_in(pd), .drive_en_in(ext_en), .level_in(ext_lv),
        .pin_level_out(pin_lv));

    ////////////////////////////////////////////////////////////////////////////////
    // Bus cycles: one strobe cycle each, read data looked at in the cycle after
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d, input logic w = 1'b0);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        word <= w;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        word <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [15:0] a, input logic w, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        word <= w;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        word <= 1'b0;
        #1 `CHK(rdata, e)
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK(pin_oe, 3'h0)
        for (int a = 16'hf250; a <= 16'hf255; a++)
            rd_chk(a[15:0], 1'b0, 16'h0);
        rd_chk(`ADDR_IRQ_MASK, 1'b0, 16'h0);
        rd_chk(16'hf2f0, 1'b0, 16'h0);
    endtask : t_reset

    // Word pairs, read-zero upper bits, and a word refused at the odd byte
    task automatic t_regs();
        wr_reg(`ADDR_DRV_LO, 16'h00ff);
        rd_chk(`ADDR_DRV_LO, 1'b0, 16'h0007);
        wr_reg(`ADDR_DRV_LO, 16'h0605, 1'b1);
        rd_chk(`ADDR_DRV_LO, 1'b1, 16'h0605);
        rd_chk(`ADDR_DRV_HI, 1'b0, 16'h0006);
        wr_reg(`ADDR_DRV_HI, 16'h0101, 1'b1);
        rd_chk(`ADDR_DRV_HI, 1'b0, 16'h0006);
        wr_reg(`ADDR_FN_LO, 16'h0302, 1'b1);
        rd_chk(`ADDR_FN_HI, 1'b0, 16'h0003);
        wr_reg(`ADDR_FN_LO, 16'h0000, 1'b1);
    endtask : t_regs

    // Every drive code with both data levels; data reads back even when not driven
    task automatic t_drive();
        pin_vec_t eo, ev;
        for (int c = 0; c < 4; c++) begin
            for (int d = 0; d < 2; d++) begin
                wr_reg(`ADDR_DRV_LO, {{8{c[1]}}, {8{c[0]}}} & 16'h0707, 1'b1);
                wr_reg(`ADDR_DATA, {13'h0, {3{d[0]}}});
                cyc(2);
                eo = (c == 0) ? 3'h0 : (c == 1) ? {3{d[0]}} : (c == 2) ? {3{~d[0]}} : 3'h7;
                ev = (c == 1) ? 3'h7 : (c == 2) ? 3'h0 : {3{d[0]}};
                `CHK(pin_oe, eo)
                `CHK(pin_lv & eo, ev & eo)
                rd_chk(`ADDR_DATA, 1'b0, {13'h0, {3{d[0]}}});
            end
        end
        wr_reg(`ADDR_DIR, 16'h0005);
        cyc(2);
        `CHK(pin_oe, 3'h2)
    endtask : t_drive

    // Input terminations and live pin level on read
    task automatic t_input();
        wr_reg(`ADDR_DIR, 16'h0007);
        for (int c = 0; c < 4; c++) begin
            wr_reg(`ADDR_DRV_LO, {{8{c[1]}}, {8{c[0]}}} & 16'h0707, 1'b1);
            cyc(2);
            `CHK(pin_oe, 3'h0)
            `CHK(pu, (c == 2) ? 3'h7 : 3'h0)
            `CHK(pd, (c == 1) ? 3'h7 : 3'h0)
        end
        @(posedge clk) ext_en <= 3'h7;
        ext_lv <= 3'h5;
        cyc(3);
        rd_chk(`ADDR_DATA, 1'b0, 16'h0005);
    endtask : t_input

    // Alternate sources must override data, in both polarities
    task automatic t_func();
        int pn[6] = '{0, 0, 0, 1, 1, 2};
        int cd[6] = '{1, 2, 3, 2, 3, 3};
        logic [7:0] lb, hb;
        @(posedge clk) ext_en <= 3'h0;
        wr_reg(`ADDR_DIR, 16'h0000);
        wr_reg(`ADDR_DRV_LO, 16'h0707, 1'b1);
        for (int p = 0; p < 2; p++) begin
            @(posedge clk) src <= {6{p[0]}};
            wr_reg(`ADDR_DATA, {13'h0, {3{~p[0]}}});
            for (int i = 0; i < 6; i++) begin
                lb = 8'(cd[i] & 1) << pn[i];
                hb = 8'(cd[i] >> 1) << pn[i];
                wr_reg(`ADDR_FN_LO, {hb, lb}, 1'b1);
                cyc(2);
                `CHK(pin_o[pn[i]], p[0])
            end
        end
        wr_reg(`ADDR_FN_LO, 16'h0400, 1'b1);
        wr_reg(`ADDR_DIR, 16'h0004);
        ext_en <= 3'h4;
        ext_lv <= 3'h4;
        cyc(3);
        `CHK(ext_clk, 1'b1)
        @(posedge clk) ext_lv <= 3'h0;
        cyc(3);
        `CHK(ext_clk, 1'b0)
        @(posedge clk) ext_en <= 3'h0;
        wr_reg(`ADDR_DIR, 16'h0000);
        wr_reg(`ADDR_DATA, 16'h0007);
        wr_reg(`ADDR_FN_LO, 16'h0002, 1'b1);
        for (int c = 0; c < 4; c++) begin
            wr_reg(`ADDR_DRV_LO, {{8{c[1]}}, {8{c[0]}}} & 16'h0707, 1'b1);
            cyc(2);
            `CHK(pin_oe[1], c >= 2)
            `CHK(pin_lv[1] | ~pin_oe[1], 1'b0 | (c < 2))
        end
        wr_reg(`ADDR_FN_LO, 16'h0000, 1'b1);
    endtask : t_func

    // Edge kinds, masking, clear, then sampled rising edge on the tick
    task automatic t_irq();
        wr_reg(`ADDR_DIR, 16'h0007);
        wr_reg(`ADDR_DRV_LO, 16'h0000, 1'b1);
        ext_en <= 3'h7;
        ext_lv <= 3'h0;
        wr_reg(`ADDR_EDGE_RISE, 16'h0005);
        wr_reg(`ADDR_EDGE_FALL, 16'h0006);
        wr_reg(`ADDR_IRQ_MASK, 16'h0005);
        wr_reg(`ADDR_IRQ_STAT, 16'h0007);
        ext_lv <= 3'h1;
        cyc(2);
        `CHK(irqv, 3'h1)
        `CHK(irq, 1'b1)
        wr_reg(`ADDR_IRQ_STAT, 16'h0001);
        ext_lv <= 3'h2;
        cyc(2);
        @(posedge clk) ext_lv <= 3'h0;
        cyc(2);
        rd_chk(`ADDR_IRQ_STAT, 1'b0, 16'h0002);
        `CHK(irq, 1'b0)
        @(posedge clk) ext_lv <= 3'h4;
        cyc(2);
        `CHK(irqv, 3'h4)
        wr_reg(`ADDR_IRQ_STAT, 16'h0006);
        rd_chk(`ADDR_IRQ_STAT, 1'b0, 16'h0000);
        @(posedge clk) ext_lv <= 3'h0;
        cyc(2);
        `CHK(irqv, 3'h4)
        wr_reg(`ADDR_EDGE_SAMP, 16'h0001);
        wr_reg(`ADDR_IRQ_STAT, 16'h0007);
        @(negedge tick);
        @(posedge clk);
        ext_lv <= 3'h1;
        @(negedge tick);
        cyc(4);
        rd_chk(`ADDR_IRQ_STAT, 1'b0, 16'h0000);
        @(negedge tick);
        cyc(4);
        rd_chk(`ADDR_IRQ_STAT, 1'b0, 16'h0001);
    endtask : t_irq

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    // Watchdog: the whole run needs well under half a millisecond
    initial begin
        #2_000_000;
        mismatches++;
        wrap_up();
    end

    // Main sequence after 16 cycles of reset
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        cyc(1);
        t_reset();
        t_regs();
        t_drive();
        t_input();
        t_func();
        t_irq();
        wrap_up();
    end
endmodule : three_pin_io_port_tb

`default_nettype wire
